// file: hw/adc_ctrl_pkg.sv
// Constants and carrier types shared by the converter control and output-mode logic
package adc_ctrl_pkg;

	// Sample word limits
	localparam int unsigned DATA_W   = 12;
	localparam logic [11:0] CODE_MIN = 12'h000;
	localparam logic [11:0] CODE_MAX = 12'hFFF;
	localparam logic [11:0] IDLE_BUS = 12'h000;

	// Register byte offsets on the bus
	localparam logic [3:0] CFG0_OFFSET   = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// Configuration register 0 value after reset and after leaving register mode
	localparam logic [15:0] CFG0_RESET = 16'h0000;

	// Configuration register 0 field positions
	localparam int unsigned CAL_BIT   = 15;
	localparam int unsigned PHASE_BIT = 14;
	localparam int unsigned PDI_BIT   = 11;
	localparam int unsigned PDQ_BIT   = 10;
	localparam int unsigned DES_BIT   = 7;
	localparam int unsigned DEQ_BIT   = 6;
	localparam int unsigned BOTH_BIT  = 5;
	localparam int unsigned RANGE_BIT = 4;

	// Interleave input selection codes
	localparam logic [1:0] SEL_I    = 2'h0;
	localparam logic [1:0] SEL_Q    = 2'h1;
	localparam logic [1:0] SEL_BOTH = 2'h2;

	// Cycle counts of the sampling clock
	localparam int unsigned CAL_LOW_MIN_CYC   = 1280;
	localparam int unsigned CAL_HIGH_MIN_CYC  = 1280;
	localparam int unsigned SETTLE_CYC        = 3;
	localparam int unsigned CAL_DLY_SHORT_CYC = 16777216;
	localparam int unsigned CAL_DLY_LONG_CYC  = 1073741824;
	localparam int unsigned CAL_RUN_CYC       = 52000000;

	// Static control pins, all from outside the clock domain
	typedef struct packed {
		logic dualEdgeSel;
		logic singleBusSel;
		logic outputPhaseSel;
		logic calPin;
		logic poweronCalWaitSel;
		logic iChanPowerdown;
		logic qChanPowerdown;
		logic patternOutSel;
		logic inputRangeSel;
		logic extCtrlEnableN;
	} ctrl_pins_t;

	// One converter result with its range indications
	typedef struct packed {
		logic [11:0] code;
		logic        aboveFs;
		logic        belowFs;
	} conv_in_t;

	// Resolved controls towards the analog front end
	typedef struct packed {
		logic       registerControlMode;
		logic       interleaveEn;
		logic [1:0] interleaveInputSel;
		logic       outPhase90;
		logic       rangeHigh;
		logic       iPowerDown;
		logic       qPowerDown;
		logic       calBusy;
	} fe_ctrl_t;

	typedef enum logic [1:0] {ST_SETTLE, ST_WAIT, ST_CAL, ST_RUN} cal_state_t;

endpackage

// file: hw/adc_control_mode_logic.sv
// Control-mode resolution, calibration sequencing and output bus steering of the dual converter
//
// The address map and the Wishbone register port were chosen for this implementation.
module adc_control_mode_logic #(
	parameter int unsigned CAL_DLY_SHORT = adc_ctrl_pkg::CAL_DLY_SHORT_CYC,
	parameter int unsigned CAL_DLY_LONG  = adc_ctrl_pkg::CAL_DLY_LONG_CYC,
	parameter int unsigned CAL_RUN       = adc_ctrl_pkg::CAL_RUN_CYC
) (
	// Clock, reset, enable
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     ce,
	// Wishbone slave
	input  wire logic                     cyc_i,
	input  wire logic                     stb_i,
	input  wire logic                     we_i,
	input  wire logic [3:0]               adr_i,
	input  wire logic [3:0]               sel_i,
	input  wire logic [31:0]              dat_i,
	output logic      [31:0]              dat_o,
	output logic                          ack_o,
	// Control pins
	input  wire adc_ctrl_pkg::ctrl_pins_t pins,
	// Converter results
	input  wire adc_ctrl_pkg::conv_in_t   convI,
	input  wire adc_ctrl_pkg::conv_in_t   convQ,
	// Front-end controls
	output adc_ctrl_pkg::fe_ctrl_t        feCtrl,
	// Output buses
	output logic      [11:0]              iOutBus,
	output logic      [11:0]              iDelayedOutBus,
	output logic      [11:0]              qOutBus,
	output logic      [11:0]              qDelayedOutBus,
	output logic                          iBusOe,
	output logic                          qBusOe,
	output logic                          iOutClock,
	output logic                          qOutClock,
	output logic                          iOverRangeFlag,
	output logic                          qOverRangeFlag
);

	typedef struct packed {
		adc_ctrl_pkg::ctrl_pins_t sync1;
		adc_ctrl_pkg::ctrl_pins_t sync2;
		adc_ctrl_pkg::cal_state_t cal;
		logic [31:0]              count;
		logic                     calSkip;
		logic                     calWaitLong;
		logic [10:0]              calLowCnt;
		logic [10:0]              calHighCnt;
		logic [15:0]              cfg;
		logic                     ack;
		logic [31:0]              rdData;
		logic                     tick;
		logic                     wordOdd;
		logic                     phaseDue;
		logic [11:0]              pendI;
		logic [11:0]              pendQ;
		logic [11:0]              pattern;
		logic [11:0]              iOut;
		logic [11:0]              iDel;
		logic [11:0]              qOut;
		logic [11:0]              qDel;
		logic                     iOe;
		logic                     qOe;
		logic                     iClk;
		logic                     qClk;
		logic                     iFlag;
		logic                     qFlag;
		adc_ctrl_pkg::fe_ctrl_t   fe;
	} state_t;

	state_t st;
	state_t next_st;

	// Clamp an overrun sample to the end codes
	function automatic logic [11:0] saturate(input adc_ctrl_pkg::conv_in_t c);
		if (c.belowFs)
			return adc_ctrl_pkg::CODE_MIN;
		else if (c.aboveFs)
			return adc_ctrl_pkg::CODE_MAX;
		return c.code;
	endfunction

	// Next state of the whole block
	always_comb
	begin
		logic        regMode;
		logic        demux;
		logic        calReq;
		logic        upd;
		logic [11:0] sI;
		logic [11:0] sQ;
		logic [31:0] dly;
		regMode = 1'b0;
		demux   = 1'b0;
		calReq  = 1'b0;
		upd     = 1'b0;
		sI      = adc_ctrl_pkg::IDLE_BUS;
		sQ      = adc_ctrl_pkg::IDLE_BUS;
		dly     = 32'h0000_0000;
		next_st = st;

		// Two-stage pin synchroniser; only sync2 feeds logic
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;

		regMode = !st.sync2.extCtrlEnableN;
		demux   = !st.sync2.singleBusSel;

		// Register control is held at default whenever pin control is selected
		if (st.sync2.extCtrlEnableN)
			next_st.cfg = adc_ctrl_pkg::CFG0_RESET;

		// Classic bus: one-cycle ack, dropped in the following cycle
		next_st.ack = cyc_i && stb_i && !st.ack;
		if (cyc_i && stb_i && !st.ack)
		begin
			next_st.rdData = 32'h0000_0000;
			if (adr_i == adc_ctrl_pkg::CFG0_OFFSET)
			begin
				next_st.rdData = {16'h0000, st.cfg};
				if (we_i && regMode)
				begin
					if (sel_i[0])
						next_st.cfg[7:0] = dat_i[7:0];
					if (sel_i[1])
						next_st.cfg[15:8] = dat_i[15:8];
				end
			end
			else if (adr_i == adc_ctrl_pkg::STATUS_OFFSET)
				next_st.rdData = {21'h00_0000, st.cal, st.fe};
		end

		// Resolve mode controls from pins or register bits
		next_st.fe.registerControlMode = regMode;
		next_st.fe.interleaveEn = regMode ? st.cfg[adc_ctrl_pkg::DES_BIT] : st.sync2.dualEdgeSel;
		if (!regMode)
			next_st.fe.interleaveInputSel = adc_ctrl_pkg::SEL_I;
		else if (st.cfg[adc_ctrl_pkg::BOTH_BIT])
			next_st.fe.interleaveInputSel = adc_ctrl_pkg::SEL_BOTH;
		else if (st.cfg[adc_ctrl_pkg::DEQ_BIT])
			next_st.fe.interleaveInputSel = adc_ctrl_pkg::SEL_Q;
		else
			next_st.fe.interleaveInputSel = adc_ctrl_pkg::SEL_I;
		next_st.fe.outPhase90 = regMode ? st.cfg[adc_ctrl_pkg::PHASE_BIT] : st.sync2.outputPhaseSel;
		next_st.fe.rangeHigh = regMode ? st.cfg[adc_ctrl_pkg::RANGE_BIT] : st.sync2.inputRangeSel;
		next_st.fe.iPowerDown = st.sync2.iChanPowerdown || (regMode && st.cfg[adc_ctrl_pkg::PDI_BIT]);
		next_st.fe.qPowerDown = st.sync2.qChanPowerdown || (regMode && st.cfg[adc_ctrl_pkg::PDQ_BIT]);
		// Powered-down channel releases its data pins
		next_st.iOe = !next_st.fe.iPowerDown;
		next_st.qOe = !next_st.fe.qPowerDown;

		// Calibration request: consecutive low then high periods
		calReq = st.sync2.calPin || (regMode && st.cfg[adc_ctrl_pkg::CAL_BIT]);
		if (calReq)
		begin
			if (st.calHighCnt != 11'(adc_ctrl_pkg::CAL_HIGH_MIN_CYC))
				next_st.calHighCnt = st.calHighCnt + 11'h001;
		end
		else
		begin
			next_st.calHighCnt = 11'h000;
			if (st.calHighCnt != 11'h000)
				next_st.calLowCnt = 11'h001;
			else if (st.calLowCnt != 11'(adc_ctrl_pkg::CAL_LOW_MIN_CYC))
				next_st.calLowCnt = st.calLowCnt + 11'h001;
		end

		// Power-on and on-command calibration sequencing
		dly = st.calWaitLong ? CAL_DLY_LONG : CAL_DLY_SHORT;
		case (st.cal)
			adc_ctrl_pkg::ST_SETTLE:
			begin
				next_st.count = st.count + 32'h0000_0001;
				if (st.count == 32'(adc_ctrl_pkg::SETTLE_CYC - 1))
				begin
					// Straps caught once the synchroniser holds valid levels
					next_st.calSkip     = st.sync2.calPin;
					next_st.calWaitLong = st.sync2.poweronCalWaitSel;
					next_st.count       = 32'h0000_0000;
					next_st.cal         = st.sync2.calPin ? adc_ctrl_pkg::ST_RUN : adc_ctrl_pkg::ST_WAIT;
				end
			end
			adc_ctrl_pkg::ST_WAIT:
			begin
				next_st.count = st.count + 32'h0000_0001;
				if (st.count >= dly - 32'h0000_0001)
				begin
					next_st.count = 32'h0000_0000;
					next_st.cal   = adc_ctrl_pkg::ST_CAL;
				end
			end
			adc_ctrl_pkg::ST_CAL:
			begin
				next_st.count = st.count + 32'h0000_0001;
				if (st.count >= 32'(CAL_RUN) - 32'h0000_0001)
				begin
					next_st.count = 32'h0000_0000;
					next_st.cal   = adc_ctrl_pkg::ST_RUN;
				end
			end
			adc_ctrl_pkg::ST_RUN:
			begin
				if (calReq && st.calLowCnt == 11'(adc_ctrl_pkg::CAL_LOW_MIN_CYC)
					&& st.calHighCnt == 11'(adc_ctrl_pkg::CAL_HIGH_MIN_CYC - 1))
				begin
					next_st.cal       = adc_ctrl_pkg::ST_CAL;
					next_st.count     = 32'h0000_0000;
					next_st.calLowCnt = 11'h000;
				end
			end
			default:
				next_st.cal = adc_ctrl_pkg::ST_SETTLE;
		endcase
		next_st.fe.calBusy = (next_st.cal == adc_ctrl_pkg::ST_CAL);

		// One sample every second clock; buses change once per sample or per pair
		next_st.tick     = !st.tick;
		next_st.phaseDue = 1'b0;
		if (st.tick)
		begin
			next_st.pattern = st.pattern + 12'h001;
			// Pattern mode disconnects the converters, flags included
			sI = st.sync2.patternOutSel ? st.pattern : saturate(convI);
			sQ = st.sync2.patternOutSel ? ~st.pattern : saturate(convQ);
			next_st.iFlag = !st.sync2.patternOutSel && (convI.aboveFs || convI.belowFs);
			next_st.qFlag = !st.sync2.patternOutSel && (convQ.aboveFs || convQ.belowFs);
			next_st.wordOdd = demux && !st.wordOdd;
			upd = !demux || st.wordOdd;
			if (demux && !st.wordOdd)
			begin
				// First of a pair is parked until its partner arrives
				next_st.pendI = sI;
				next_st.pendQ = sQ;
			end
			else if (st.fe.interleaveEn)
			begin
				// Rising-edge converter on the main bus, falling-edge one on the delayed bus
				next_st.iOut = sI;
				next_st.iDel = sQ;
				next_st.qOut = demux ? st.pendI : adc_ctrl_pkg::IDLE_BUS;
				next_st.qDel = demux ? st.pendQ : adc_ctrl_pkg::IDLE_BUS;
			end
			else
			begin
				next_st.iOut = sI;
				next_st.qOut = sQ;
				next_st.iDel = demux ? st.pendI : adc_ctrl_pkg::IDLE_BUS;
				next_st.qDel = demux ? st.pendQ : adc_ctrl_pkg::IDLE_BUS;
			end
		end

		// DDR clock: toggle with the data, or one clock later for the midway phase
		if ((upd && !st.fe.outPhase90) || st.phaseDue)
		begin
			next_st.iClk = st.fe.iPowerDown ? st.iClk : !st.iClk;
			next_st.qClk = st.fe.qPowerDown ? st.qClk : !st.qClk;
		end
		else if (upd)
			next_st.phaseDue = 1'b1;
	end

	// State register; the enable freezes everything
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st     <= '0;
			st.cfg <= adc_ctrl_pkg::CFG0_RESET;
			// Synchroniser starts in pin control, so no false register mode follows reset
			st.sync1.extCtrlEnableN <= 1'b1;
			st.sync2.extCtrlEnableN <= 1'b1;
		end
		else if (ce)
			st <= next_st;
	end

	// Outputs straight from the state register
	assign dat_o          = st.rdData;
	assign ack_o          = st.ack;
	assign feCtrl         = st.fe;
	assign iOutBus        = st.iOut;
	assign iDelayedOutBus = st.iDel;
	assign qOutBus        = st.qOut;
	assign qDelayedOutBus = st.qDel;
	assign iBusOe         = st.iOe;
	assign qBusOe         = st.qOe;
	assign iOutClock      = st.iClk;
	assign qOutClock      = st.qClk;
	assign iOverRangeFlag = st.iFlag;
	assign qOverRangeFlag = st.qFlag;

	// Checks on the behaviour above; a frozen enable suspends them
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !ce);

	AST_SAT_LOW: assert property (st.tick && !st.sync2.patternOutSel && convI.belowFs
		&& (st.sync2.singleBusSel || st.wordOdd) |=> iOutBus == adc_ctrl_pkg::CODE_MIN)
		else $error("Below-range sample not clamped to zero");

	AST_SAT_HIGH: assert property (st.tick && st.sync2.singleBusSel && !st.sync2.patternOutSel
		&& convQ.aboveFs && !convQ.belowFs && !st.fe.interleaveEn |=> qOutBus == adc_ctrl_pkg::CODE_MAX)
		else $error("Above-range sample not clamped to all ones");

	AST_RANGE_FLAG: assert property (st.tick && !st.sync2.patternOutSel
		&& (convQ.aboveFs || convQ.belowFs) |=> qOverRangeFlag ##1 qOverRangeFlag)
		else $error("Over-range flag not raised");

	AST_DEMUX_HALF: assert property (st.tick && !st.sync2.singleBusSel && !st.wordOdd
		|=> $stable(iOutBus) && $stable(iDelayedOutBus))
		else $error("Demux bus changed on the first sample of a pair");

	AST_SINGLE_BUS: assert property (st.tick && st.sync2.singleBusSel && !st.fe.interleaveEn
		|=> iDelayedOutBus == adc_ctrl_pkg::IDLE_BUS && qDelayedOutBus == adc_ctrl_pkg::IDLE_BUS)
		else $error("Second bus active in non-demux mode");

	AST_PIN_DEFAULT: assert property (st.sync2.extCtrlEnableN
		|=> st.cfg == adc_ctrl_pkg::CFG0_RESET && !st.fe.registerControlMode
		&& st.fe.interleaveInputSel == adc_ctrl_pkg::SEL_I)
		else $error("Registers not at default under pin control");

	AST_REG_INTERLEAVE: assert property (!st.sync2.extCtrlEnableN
		|=> st.fe.interleaveEn == $past(st.cfg[adc_ctrl_pkg::DES_BIT])
		&& st.fe.outPhase90 == $past(st.cfg[adc_ctrl_pkg::PHASE_BIT]))
		else $error("Register mode not taken from configuration bits");

	AST_PHASE0: assert property (st.tick && !st.fe.outPhase90 && !st.fe.iPowerDown
		&& (st.sync2.singleBusSel || st.wordOdd) |=> iOutClock != $past(iOutClock))
		else $error("Data clock did not toggle with the data");

	AST_PHASE90: assert property (st.tick && st.fe.outPhase90 && !st.fe.iPowerDown
		&& st.sync2.singleBusSel |=> $stable(iOutClock) ##1 $changed(iOutClock))
		else $error("Midway data clock toggle misplaced");

	AST_PD_FLOAT: assert property (st.sync2.iChanPowerdown
		|=> !iBusOe && feCtrl.iPowerDown)
		else $error("Powered-down channel still drives its bus");

	AST_REG_PDQ: assert property (!st.sync2.extCtrlEnableN && st.cfg[adc_ctrl_pkg::PDQ_BIT]
		&& !st.sync2.qChanPowerdown |=> !qBusOe)
		else $error("Register power-down of Q not applied");

	AST_CAL_START: assert property (st.cal == adc_ctrl_pkg::ST_RUN && st.sync2.calPin
		&& st.calLowCnt == 11'(adc_ctrl_pkg::CAL_LOW_MIN_CYC)
		&& st.calHighCnt == 11'(adc_ctrl_pkg::CAL_HIGH_MIN_CYC - 1) |=> feCtrl.calBusy)
		else $error("On-command calibration did not start");

	AST_CAL_SKIP: assert property (st.cal == adc_ctrl_pkg::ST_SETTLE
		&& st.count == 32'(adc_ctrl_pkg::SETTLE_CYC - 1) && st.sync2.calPin
		|=> st.cal == adc_ctrl_pkg::ST_RUN && st.calSkip && !feCtrl.calBusy)
		else $error("Power-on calibration not skipped");

	COV_DES_DEMUX: cover property (st.fe.interleaveEn && !st.sync2.singleBusSel && st.tick && st.wordOdd);
	COV_CAL_DONE: cover property (st.cal == adc_ctrl_pkg::ST_CAL ##1 st.cal == adc_ctrl_pkg::ST_RUN);
	COV_REG_WRITE: cover property (ack_o && we_i && feCtrl.registerControlMode);
	COV_OVERRANGE: cover property (iOverRangeFlag && qOverRangeFlag);

endmodule

// file: testbench/capture_host_model.sv
// Capture-side model: times word updates of one channel against its data clock
module capture_host_model (
	// Clock
	input wire logic        clk,
	// Captured channel
	input wire logic [11:0] bus,
	input wire logic        outClock,
	input wire logic        busOe
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [11:0] lastBus   = 12'h000;
	logic        lastClock = 1'b0;
	int          gap       = 0;
	int          lastGap   = 0;
	int          skewCount = 0;
	int          flushLeft = 0;

	// Gap between word changes; changes not met by a clock edge in the same cycle
	always @(posedge clk)
	begin
		lastBus <= bus;
		lastClock <= outClock;
		gap <= gap + 1;
		if (bus !== lastBus)
		begin
			lastGap <= gap;
			gap <= 1;
			if (outClock === lastClock)
				skewCount <= skewCount + 1;
		end
		// Stale pipeline words after a power-down are not trusted
		if (busOe !== 1'b1)
			flushLeft <= 4;
		else if (bus !== lastBus && flushLeft > 0)
			flushLeft <= flushLeft - 1;
	end
endmodule

// file: testbench/tb.sv
// Self-checking bench for the converter control and output-mode logic
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// Clock, reset and bus
	logic                   clk = 1'b0;
	logic                   rstN;
	logic                   cyc, stb, we, ack;
	logic [3:0]             adr, sel;
	logic [31:0]            datW, datR, rd;
	// Pins, converter side, outputs
	adc_ctrl_pkg::ctrl_pins_t pins;
	adc_ctrl_pkg::conv_in_t   convI, convQ;
	adc_ctrl_pkg::fe_ctrl_t   feCtrl, expFe;
	logic [11:0]            iOut, iDel, qOut, qDel;
	logic                   iOe, qOe, iClk, qClk, iOr, qOr, ramp;
	int                     failCount = 0;
	int                     checksDone = 0;
	int                     cycleNo = 0;
	int                     t0, n, s0;

	// Short calibration counts keep the run brief
	adc_control_mode_logic #(
		.CAL_DLY_SHORT(20),
		.CAL_DLY_LONG (40),
		.CAL_RUN      (30)
	) adc_control_mode_logic_i (
		.clk(clk), .rst_n(rstN), .ce(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(datW), .dat_o(datR), .ack_o(ack), .pins(pins), .convI(convI), .convQ(convQ), .feCtrl(feCtrl),
		.iOutBus(iOut), .iDelayedOutBus(iDel), .qOutBus(qOut), .qDelayedOutBus(qDel), .iBusOe(iOe),
		.qBusOe(qOe), .iOutClock(iClk), .qOutClock(qClk), .iOverRangeFlag(iOr), .qOverRangeFlag(qOr)
	);

	capture_host_model capture_host_model_i (
		.clk(clk), .bus(iOut), .outClock(iClk), .busOe(iOe)
	);

	// Clock, cycle count and ramping converter codes
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cycleNo <= cycleNo + 1;
		if (ramp)
		begin
			convI.code <= convI.code + 12'h001;
			convQ.code <= convQ.code + 12'h002;
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			failCount++;
		end
	endtask

	// Classic single cycle; called just after a rising edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		datW <= d;
		k = 0;
		// Request stands until the rising edge that sees ack high
		do
		begin
			@(posedge clk);
			k++;
		end
		while (ack !== 1'b1 && k < 16);
		if (ack !== 1'b1)
		begin
			$display("Error bus ack expected 1 seen %b", ack);
			failCount++;
			report_and_stop();
		end
		// Read data taken at the ack edge, then one idle cycle
		rd = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	// Reset with straps set, then poll the state until run
	task automatic powerUp(input logic cal, input logic wsel, input int expMin);
		rstN <= 1'b0;
		pins.calPin <= cal;
		pins.poweronCalWaitSel <= wsel;
		repeat (8) @(posedge clk);
		rstN <= 1'b1;
		t0 = cycleNo;
		n = 0;
		do
		begin
			wb(1'b0, adc_ctrl_pkg::STATUS_OFFSET, 32'h0000_0000);
			n++;
		end
		while (rd[10:9] !== 2'h3 && n < 60);
		chk("startup span", 32'h0000_0001, 32'(cycleNo - t0 >= expMin && cycleNo - t0 <= expMin + 16));
	endtask

	initial
	begin
		int k;
		rstN = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		sel = 4'h0;
		datW = 32'h0000_0000;
		ramp = 1'b0;
		pins = '0;
		pins.extCtrlEnableN = 1'b1;
		pins.singleBusSel = 1'b1;
		convI = '0;
		convQ = '0;
		// Start-up for each strap setting
		powerUp(1'b0, 1'b0, 53);
		powerUp(1'b0, 1'b1, 73);
		powerUp(1'b1, 1'b0, 0);
		pins.calPin <= 1'b0;
		$display("startup test done");
		// Pin control drops register writes
		wb(1'b1, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_FFFF);
		wb(1'b0, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_0000);
		chk("cfg in pin mode", 32'h0000_0000, rd);
		chk("register mode", 32'h0000_0000, 32'(feCtrl.registerControlMode));
		wb(1'b0, 4'h8, 32'h0000_0000);
		chk("unmapped read", 32'h0000_0000, rd);
		// Register control, then back to pins
		pins.extCtrlEnableN <= 1'b0;
		repeat (4) @(posedge clk);
		wb(1'b1, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_4CD0);
		wb(1'b0, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_0000);
		chk("cfg readback", 32'h0000_4CD0, rd);
		expFe = {1'b1, 1'b1, adc_ctrl_pkg::SEL_Q, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		chk("front end", 32'(expFe), 32'(feCtrl));
		chk("I enable", 32'h0000_0000, 32'(iOe));
		chk("Q enable", 32'h0000_0000, 32'(qOe));
		wb(1'b1, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_00A0);
		chk("both inputs", 32'(adc_ctrl_pkg::SEL_BOTH), 32'(feCtrl.interleaveInputSel));
		pins.extCtrlEnableN <= 1'b1;
		repeat (4) @(posedge clk);
		wb(1'b0, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_0000);
		chk("cfg after pin mode", 32'h0000_0000, rd);
		$display("control mode test done");
		// Saturation and flags: below, above, both
		for (k = 1; k < 4; k++)
		begin
			convI <= {12'h123, 2'(k)};
			convQ <= {12'h456, 2'b00};
			repeat (8) @(posedge clk);
			chk("I word", (k == 2) ? 32'h0000_0FFF : 32'h0000_0000, 32'(iOut));
			chk("I flag", 32'h0000_0001, 32'(iOr));
			chk("Q word", 32'h0000_0456, 32'(qOut));
			chk("Q flag", 32'h0000_0000, 32'(qOr));
		end
		$display("saturation test done");
		// Word rates and data clock phase; clamped samples would hide the ramp
		convI.belowFs <= 1'b0;
		convI.aboveFs <= 1'b0;
		ramp <= 1'b1;
		repeat (20) @(posedge clk);
		chk("single bus gap", 32'h0000_0002, capture_host_model_i.lastGap);
		chk("unused bus", 32'h0000_0000, 32'(iDel));
		s0 = capture_host_model_i.skewCount;
		repeat (20) @(posedge clk);
		chk("0 degree skew", s0, capture_host_model_i.skewCount);
		pins.outputPhaseSel <= 1'b1;
		repeat (10) @(posedge clk);
		s0 = capture_host_model_i.skewCount;
		repeat (20) @(posedge clk);
		chk("90 degree skew", 32'h0000_0001, 32'(capture_host_model_i.skewCount > s0));
		pins.outputPhaseSel <= 1'b0;
		pins.singleBusSel <= 1'b0;
		repeat (20) @(posedge clk);
		chk("demux gap", 32'h0000_0004, capture_host_model_i.lastGap);
		chk("demux step", 32'h0000_0002, 32'(12'(iOut - iDel)));
		// Ramp must stop before a fixed code is loaded, or the two updates race
		ramp <= 1'b0;
		@(posedge clk);
		$display("rate test done");
		// Interleaving on the I input
		pins.singleBusSel <= 1'b1;
		pins.dualEdgeSel <= 1'b1;
		convQ <= {12'h456, 2'b00};
		repeat (10) @(posedge clk);
		chk("Q bus idle", 32'h0000_0000, 32'(qOut));
		chk("second edge word", 32'h0000_0456, 32'(iDel));
		chk("interleave", 32'h0000_0001, 32'(feCtrl.interleaveEn));
		chk("input select", 32'(adc_ctrl_pkg::SEL_I), 32'(feCtrl.interleaveInputSel));
		pins.dualEdgeSel <= 1'b0;
		$display("interleave test done");
		// Power-down, range and pattern pins through the synchroniser
		pins.iChanPowerdown <= 1'b1;
		pins.inputRangeSel <= 1'b1;
		pins.patternOutSel <= 1'b1;
		convI <= {12'h123, 2'b10};
		repeat (2) @(posedge clk);
		chk("range unsynced", 32'h0000_0000, 32'(feCtrl.rangeHigh));
		repeat (6) @(posedge clk);
		chk("I enable", 32'h0000_0000, 32'(iOe));
		chk("Q enable", 32'h0000_0001, 32'(qOe));
		chk("range", 32'h0000_0001, 32'(feCtrl.rangeHigh));
		chk("pattern flag", 32'h0000_0000, 32'(iOr));
		// Wake the channel with moving data so the receiver can flush its pipeline
		pins.iChanPowerdown <= 1'b0;
		pins.patternOutSel <= 1'b0;
		convI.aboveFs <= 1'b0;
		ramp <= 1'b1;
		repeat (20) @(posedge clk);
		chk("I enable back", 32'h0000_0001, 32'(iOe));
		chk("flush words left", 32'h0000_0000, capture_host_model_i.flushLeft);
		$display("pin test done");
		// Calibration on command: pin low, then register bit high
		pins.extCtrlEnableN <= 1'b0;
		repeat (1300) @(posedge clk);
		wb(1'b1, adc_ctrl_pkg::CFG0_OFFSET, 32'h0000_8000);
		n = 0;
		while (feCtrl.calBusy !== 1'b1 && n < 1400)
		begin
			@(posedge clk);
			n++;
		end
		chk("busy delay", 32'h0000_0001, 32'(n >= 1274 && n <= 1284));
		$display("calibration test done");
		report_and_stop();
	end
endmodule
